// >>> bench/dtio_wiring.sv
// Model of the wiring at the terminal pins.
// Assumes the bench sets pin levels and switches the watchdog pulser.
module dtio_wiring (
  // Clock
  input wire logic clk,
  // Control
  input wire logic pulse_en,
  input wire logic [7:0] pins,
  // Pins
  output logic [7:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ph;
  // The pulser stands still, at its first phase, while switched off.
  always_ff @(posedge clk) begin
    if (!pulse_en) begin
      ph <= 4'h0;
    end else begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
    end
  end
  always_comb begin
    din = pins;
    if (pulse_en) din[2] = (ph < 4'h3);
  end
endmodule : dtio_wiring

// >>> bench/tb_drive_terminal_and_analog_io.sv
// Self-checking bench of the drive terminal block.
// Assumes TICK_CYCLES of 10 and the watchdog on the third input.
module tb_drive_terminal_and_analog_io;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic up = 1'b0, dn = 1'b0, stp = 1'b0, mstp = 1'b0, pen = 1'b0;
  logic rly = 1'b0, fs, es, co, de, tr, ro, lk, rk, d1, d2;
  logic [15:0] rf = 16'h0000;
  logic [1:0] aor;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, expq[$];
  logic [7:0] pins = 8'h00, din, dis, e;
  logic [11:0] a1, a2, aoc;
  logic [5:0] seg;
  logic [17:0] f1, f2;
  int fails = 0, check_count = 0, seed = 83, i;
  initial forever #25 clk = ~clk;
  dtio_wiring u_wire (.clk(clk), .pulse_en(pen), .pins(pins), .din(din));
  dtio_top #(.TICK_CYCLES(10)) u_dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .ADDR(addr), .WR_DATA(wdat), .WR_STROBE(wr), .RD_STROBE(rd),
    .RD_DATA(rdat), .DIN(din), .KEY_UP(up), .KEY_DOWN(dn), .STOPPED(stp),
    .MOTOR_STOPPED(mstp), .RUN_FREQ(rf), .RELAY_REQ(rly),
    .DO1_REQ(rly), .DO2_REQ(rly), .AIN1_CODE(a1), .AIN2_CODE(a2),
    .FREE_STOP(fs), .EMERG_STOP(es), .COAST_REQ(co), .DECEL_REQ(de),
    .WD_TRIP(tr), .DI_STATE(dis), .DIAG_SEG(seg), .RELAY_OUT(ro),
    .DO1_OUT(d1), .DO2_OUT(d2), .LOCAL_KEYPAD_EN(lk), .REMOTE_KEYPAD_EN(rk),
    .AI1_FREQ(f1), .AI2_FREQ(f2), .AO1_CODE(aoc), .AO1_RANGE(aor));
  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, input logic [31:0] x);
    @(posedge clk);
    rd <= 1'b1; addr <= a; expq.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic press(input logic u);
    up <= u; dn <= !u;
    settle(4);
    up <= 1'b0; dn <= 1'b0;
    settle(4);
  endtask : press
  task automatic wait_hi(input logic b);
    for (int k = 0; k < 80 && (b ? de : tr) !== 1'b1; k++) settle(1);
    if ((b ? de : tr) !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask : wait_hi
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk(rdat, expq.pop_front());
  end
  // ==========================================================
  // Main sequence
  initial begin
    a1 = 12'($random(seed));
    a2 = 12'($random(seed));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rreg(dtio_pkg::OFS_FILT, 32'h0000000a);
    rreg(dtio_pkg::OFS_CFG, 32'h00000028);
    rreg(5'h1f, 32'h0);
    rreg(dtio_pkg::OFS_MON[0], {20'h0, a1});
    rreg(dtio_pkg::OFS_MON[1], {20'h0, a2});
    wreg(dtio_pkg::OFS_WDT, 32'h0);
    wreg(dtio_pkg::OFS_FILT, 32'h1);
    for (i = 0; i < 4; i++) begin
      wreg(dtio_pkg::OFS_CFG, (32'(i) << 3) | 32'(i[0] * 3));
      settle(8);
      chk({lk, rk}, {i != 1, i == 1 || i == 2});
      chk({fs, es}, {2{!i[0]}});
    end
    $display("Keypad and polarity test done");
    for (i = 0; i < 4; i++) begin
      pins <= 8'($random(seed));
      e = 8'($random(seed));
      wreg(dtio_pkg::OFS_TERM, {8'h0, e, 16'h0210});
      settle(8);
      e = e ^ pins;
      chk(dis, e);
      chk(seg, {e[5], ~e[4], e[3], ~e[2], e[1], ~e[0]});
      rreg(dtio_pkg::OFS_STATUS, {16'h0, e, 8'h0});
    end
    pins <= 8'h00;
    wreg(dtio_pkg::OFS_TERM, 32'h00000210);
    wreg(dtio_pkg::OFS_FILT, 32'h14);
    pins <= 8'h01;
    settle(12);
    chk(dis[0], 1'b0);
    settle(20);
    chk(dis[0], 1'b1);
    pins <= 8'h00;
    wreg(dtio_pkg::OFS_FILT, 32'h1);
    settle(100);
    chk(tr, 1'b0);
    $display("Terminal test done");
    pen <= 1'b1;
    wreg(dtio_pkg::OFS_WDT, 32'h3);
    settle(100);
    chk(tr, 1'b0);
    pen <= 1'b0;
    wait_hi(1'b0);
    chk(co, 1'b1);
    rreg(dtio_pkg::OFS_STATUS, 32'h00000003);
    wreg(dtio_pkg::OFS_STATUS, 32'h1);
    wreg(dtio_pkg::OFS_CFG, 32'h4);
    chk({tr, co}, 2'b00);
    wait_hi(1'b1);
    chk(tr, 1'b0);
    mstp <= 1'b1;
    settle(3);
    chk({tr, de}, 2'b10);
    wreg(dtio_pkg::OFS_WDT, 32'h0);
    wreg(dtio_pkg::OFS_STATUS, 32'h1);
    $display("Watchdog test done");
    stp <= 1'b1;
    wreg(dtio_pkg::OFS_SIM, 32'h4);
    for (i = 0; i < 3; i++) press(1'b1);
    chk(aoc, 12'h003);
    for (i = 0; i < 5; i++) press(1'b0);
    chk(aoc, 12'h000);
    wreg(dtio_pkg::OFS_SIM, 32'h1);
    press(1'b1);
    chk(ro, 1'b1);
    wreg(dtio_pkg::OFS_SIM, 32'h2);
    press(1'b1);
    chk({d2, d1, ro}, 3'b010);
    wreg(dtio_pkg::OFS_SIM, 32'h0);
    settle(2);
    chk({d2, d1, ro}, 3'b000);
    rly <= 1'b1;
    settle(2);
    chk({d2, d1, ro}, 3'b111);
    rly <= 1'b0;
    $display("Simulation test done");
    a1 <= 12'hfff;
    settle(60);
    chk(f1, 18'd5000);
    a1 <= 12'h000;
    wreg(dtio_pkg::OFS_SET[0], 32'h00c80000);
    settle(60);
    rreg(dtio_pkg::OFS_FREQ[0], 32'hffffec78);
    wreg(dtio_pkg::OFS_MISC[0], 32'h0001400a);
    a1 <= 12'h807;
    settle(60);
    chk(f1, 18'h0);
    wreg(dtio_pkg::OFS_SET[0], 32'h00c80064);
    settle(60);
    chk(f1 == 18'h0, 1'b0);
    wreg(dtio_pkg::OFS_MISC[0], 32'h00010014);
    a1 <= 12'hfff;
    settle(60);
    chk(f1, 18'd10000);
    wreg(dtio_pkg::OFS_MAINF, 32'd2500);
    wreg(dtio_pkg::OFS_CFG, 32'h80);
    settle(60);
    chk(f1, 18'd5000);
    wreg(dtio_pkg::OFS_MISC[0], 32'h00640014);
    a1 <= 12'h000;
    settle(60);
    chk(f1 > 18'd4000 && f1 < 18'd5000, 1'b1);
    rf <= 16'd2505;
    settle(3);
    chk({aor, aoc}, {2'h0, 12'd2049});
    wreg(dtio_pkg::OFS_CFG, 32'h40);
    rf <= 16'd5;
    settle(3);
    chk({aor, aoc}, {2'h2, 12'h333});
    wreg(dtio_pkg::OFS_COMP, 32'd50);
    rf <= 16'd6000;
    settle(3);
    chk(aoc, 12'd2047);
    $display("Analog test done");
    wrap_up();
  end
endmodule : tb_drive_terminal_and_analog_io

// >>> hw/dtio_pkg.sv
// Constants, register map and state types of the drive terminal block.
// Assumes a single 20 MHz clock shared by the bus and the drive logic.
package dtio_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_TERM = 5'h01;
  localparam logic [4:0] OFS_FILT = 5'h02;
  localparam logic [4:0] OFS_WDT = 5'h03;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [1:0][4:0] OFS_MON = {5'h06, 5'h05};
  localparam logic [1:0][4:0] OFS_LIM = {5'h0a, 5'h07};
  localparam logic [1:0][4:0] OFS_SET = {5'h0b, 5'h08};
  localparam logic [1:0][4:0] OFS_MISC = {5'h0c, 5'h09};
  localparam logic [4:0] OFS_MAXF = 5'h0d;
  localparam logic [4:0] OFS_MAINF = 5'h0e;
  localparam logic [4:0] OFS_AOF = 5'h0f;
  localparam logic [4:0] OFS_COMP = 5'h10;
  localparam logic [4:0] OFS_SIM = 5'h11;
  localparam logic [4:0] OFS_AOCODE = 5'h12;
  localparam logic [1:0][4:0] OFS_FREQ = {5'h14, 5'h13};
  // ==========================================================
  // Field positions
  localparam int P_FREE = 0;
  localparam int P_ESTOP = 1;
  localparam int P_WDMODE = 2;
  localparam int P_KEYPAD = 3;
  localparam int P_AORANGE = 5;
  localparam int P_SEC = 7;
  localparam int P_TESTOP = 4;
  localparam int P_TWD = 8;
  localparam int P_INV = 16;
  localparam int P_HIGH = 16;
  localparam int P_DEAD = 8;
  localparam int P_FTIME = 16;
  localparam int P_DI = 8;
  // ==========================================================
  // Reset values
  localparam logic [6:0] RST_FILT = 7'h0a;
  localparam logic [14:0] RST_WDT = 15'h0064;
  localparam logic [1:0] RST_KEYPAD = 2'h1;
  localparam logic [1:0] RST_AORANGE = 2'h1;
  localparam logic [15:0] RST_AOLO = 16'h0005;
  localparam logic [15:0] RST_FREQ = 16'h1388;
  localparam logic [6:0] RST_COMP = 7'h64;
  localparam logic [1:0][11:0] RST_LOLIM = {12'h004, 12'h010};
  localparam logic [11:0] RST_HILIM = 12'hfff;
  localparam logic [7:0] RST_LSET = 8'h64;
  localparam logic [7:0] RST_HSET = 8'hc8;
  localparam logic [6:0] RST_GAIN = 7'h0a;
  localparam logic [8:0] RST_FTIME = 9'h001;
  localparam logic [2:0] RST_TESTOP = 3'h1;
  localparam logic [2:0] RST_TWD = 3'h2;
  // ==========================================================
  // Scaling and codes
  localparam logic [11:0] CODE_FULL = 12'hfff;
  localparam logic [11:0] CODE_4MA = 12'h333;
  localparam int PCT_ONE = 100;
  localparam int GAIN_DIV = 1000;
  localparam int FRAC = 8;
  localparam int FREQ_LIM = 131071;
  localparam logic [1:0][8:0] FTIME_MAX = {9'h1f4, 9'h064};
  localparam logic [1:0] KP_REMOTE = 2'h1;
  localparam logic [1:0] KP_BOTH = 2'h2;
  localparam logic [1:0] AO_4_20 = 2'h2;
  localparam logic [2:0] SIM_RELAY = 3'h1;
  localparam logic [2:0] SIM_AO1 = 3'h4;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {WD_RUN, WD_DECEL, WD_TRIP} dtio_wd_t;
  typedef struct packed {
    logic [11:0] low_lim;
    logic [11:0] high_lim;
    logic [7:0] low_set;
    logic [7:0] high_set;
    logic [6:0] gain;
    logic [7:0] dead;
    logic [8:0] ftime;
  } dtio_ai_t;
  typedef struct packed {
    logic free_pol, estop_pol, wd_mode;
    logic [1:0] keypad, ao_range, sec;
    logic [2:0] t_free, t_estop, t_wd;
    logic [7:0] inv_mask;
    logic [6:0] filt;
    logic [14:0] wdt;
    dtio_ai_t [1:0] ai;
    logic [15:0] maxf, mainf, ao_lo, ao_hi;
    logic [6:0] comp;
    logic [2:0] sim;
    logic [11:0] sim_code;
    logic [2:0] force_on;
    logic [7:0] din1, din2;
    logic [1:0] key1, key2, key_q;
    logic [7:0][6:0] fcnt;
    logic [7:0] di_acc;
    logic wd_prev, coast;
    dtio_wd_t wds;
    logic [31:0] tick;
    logic [14:0] wd_cnt;
    logic [1:0][11:0] mon;
    logic [1:0][19:0] y;
    logic [1:0][17:0] freq;
    logic [11:0] ao_code;
    logic free_stop, estop, relay, do1, do2, lkp, rkp;
    logic decel, trip;
    logic [7:0] di_state;
    logic [5:0] diag;
    logic [31:0] rdata;
  } dtio_st_t;
endpackage : dtio_pkg

// >>> hw/dtio_top.sv
// Terminal input and analog input/output conditioning of a drive.
// Assumes pins DIN and KEY come from outside; all other inputs are
// driven by drive logic on SYS_CLK.
module dtio_top #(
  parameter int TICK_CYCLES = dtio_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  output logic [31:0] RD_DATA,
  // Terminal pins
  input wire logic [7:0] DIN,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  // Drive state
  input wire logic STOPPED,
  input wire logic MOTOR_STOPPED,
  input wire logic [15:0] RUN_FREQ,
  input wire logic RELAY_REQ,
  input wire logic DO1_REQ,
  input wire logic DO2_REQ,
  input wire logic [11:0] AIN1_CODE,
  input wire logic [11:0] AIN2_CODE,
  // Stop and watchdog outputs
  output logic FREE_STOP,
  output logic EMERG_STOP,
  output logic COAST_REQ,
  output logic DECEL_REQ,
  output logic WD_TRIP,
  // Terminal outputs
  output logic [7:0] DI_STATE,
  output logic [5:0] DIAG_SEG,
  output logic RELAY_OUT,
  output logic DO1_OUT,
  output logic DO2_OUT,
  output logic LOCAL_KEYPAD_EN,
  output logic REMOTE_KEYPAD_EN,
  // Analog outputs
  output logic [17:0] AI1_FREQ,
  output logic [17:0] AI2_FREQ,
  output logic [11:0] AO1_CODE,
  output logic [1:0] AO1_RANGE
);
  // ==========================================================
  // Functions
  // Maps a filtered code to a signed frequency in 0.01 Hz.
  function automatic logic [17:0] ai_scale(input logic [11:0] x,
      input dtio_pkg::dtio_ai_t c, input logic [15:0] rf);
    int lo, hi, mid, pct, f;
    lo = int'(c.low_lim);
    hi = int'(c.high_lim);
    mid = (lo + hi) / 2;
    if (int'(x) <= lo) begin
      pct = int'(c.low_set);
    end else if (int'(x) >= hi) begin
      pct = int'(c.high_set);
    end else begin
      pct = int'(c.low_set) + (int'(c.high_set) - int'(c.low_set))
          * (int'(x) - lo) / (hi - lo);
    end
    // Percent around 1.00 times reference times gain in tenths.
    f = (pct - dtio_pkg::PCT_ONE) * int'(rf) * int'(c.gain)
        / dtio_pkg::GAIN_DIV;
    if (int'(c.low_set) < dtio_pkg::PCT_ONE
        && int'(x) >= mid - int'(c.dead)
        && int'(x) <= mid + int'(c.dead)) begin
      f = 0;
    end
    if (f > dtio_pkg::FREQ_LIM) begin
      f = dtio_pkg::FREQ_LIM;
    end
    if (f < -dtio_pkg::FREQ_LIM) begin
      f = -dtio_pkg::FREQ_LIM;
    end
    return 18'(f);
  endfunction : ai_scale

  // One first-order low-pass step on a code with 8 fraction bits.
  function automatic logic [19:0] ai_filt(input logic [19:0] y,
      input logic [11:0] x, input logic [8:0] tc,
      input logic [8:0] tmax);
    int t, d;
    t = int'(tc);
    if (t < 1) begin
      t = 1;
    end
    if (t > int'(tmax)) begin
      t = int'(tmax);
    end
    d = (int'(x) << dtio_pkg::FRAC) - int'(y);
    return 20'(int'(y) + d / t);
  endfunction : ai_filt

  // ==========================================================
  // State
  dtio_pkg::dtio_st_t s, n;
  logic tick_hit, wd_pulse, key_up, key_dn, ao_sim, wd_due;
  logic [7:0] di_valid;
  logic [6:0] filt_eff;

  assign tick_hit = s.tick >= 32'(TICK_CYCLES - 1);
  assign key_up = s.key2[0] & ~s.key_q[0];
  assign key_dn = s.key2[1] & ~s.key_q[1];
  assign di_valid = s.di_acc ^ s.inv_mask;
  assign wd_pulse = di_valid[s.t_wd] & ~s.wd_prev;
  assign ao_sim = STOPPED && s.sim == dtio_pkg::SIM_AO1;
  assign filt_eff = (s.filt == 7'h00) ? 7'h01 : s.filt;
  assign wd_due = s.wds == dtio_pkg::WD_RUN && s.wdt != 15'h0000
      && !wd_pulse && s.wd_cnt >= s.wdt;

  always_comb begin
    int f, lo, hi, mn, l, cde;
    f = 0;
    lo = 0;
    hi = 0;
    mn = 0;
    l = 0;
    cde = 0;
    n = s;
    n.rdata = 32'h0000_0000;
    // ==========================================================
    // Pin synchronisers
    n.din1 = DIN;
    n.din2 = s.din1;
    n.key1 = {KEY_DOWN, KEY_UP};
    n.key2 = s.key1;
    n.key_q = s.key2;
    // ==========================================================
    // Terminal filter and stop inputs
    for (int i = 0; i < 8; i++) begin
      if (s.din2[i] == s.di_acc[i]) begin
        n.fcnt[i] = 7'h00;
      end else if (s.fcnt[i] + 7'h01 >= filt_eff) begin
        n.di_acc[i] = s.din2[i];
        n.fcnt[i] = 7'h00;
      end else begin
        n.fcnt[i] = s.fcnt[i] + 7'h01;
      end
    end
    n.di_state = n.di_acc ^ s.inv_mask;
    for (int k = 0; k < 3; k++) begin
      n.diag[2 * k] = ~n.di_state[2 * k];
      n.diag[2 * k + 1] = n.di_state[2 * k + 1];
    end
    n.free_stop = s.free_pol ? n.di_acc[s.t_free]
        : ~n.di_acc[s.t_free];
    n.estop = s.estop_pol ? n.di_acc[s.t_estop]
        : ~n.di_acc[s.t_estop];
    n.lkp = s.keypad != dtio_pkg::KP_REMOTE;
    n.rkp = s.keypad == dtio_pkg::KP_REMOTE
        || s.keypad == dtio_pkg::KP_BOTH;
    // ==========================================================
    // Watchdog
    n.tick = tick_hit ? 32'h0 : s.tick + 32'h1;
    n.wd_prev = di_valid[s.t_wd];
    case (s.wds)
      dtio_pkg::WD_RUN: begin
        if (s.wdt == 15'h0000 || wd_pulse) begin
          n.wd_cnt = 15'h0000;
        end else if (s.wd_cnt >= s.wdt) begin
          if (s.wd_mode) begin
            n.wds = dtio_pkg::WD_DECEL;
          end else begin
            n.wds = dtio_pkg::WD_TRIP;
            n.coast = 1'b1;
          end
        end else if (tick_hit) begin
          n.wd_cnt = s.wd_cnt + 15'h0001;
        end
      end
      dtio_pkg::WD_DECEL: begin
        if (MOTOR_STOPPED) begin
          n.wds = dtio_pkg::WD_TRIP;
        end
      end
      dtio_pkg::WD_TRIP: begin
        if (WR_STROBE && ADDR == dtio_pkg::OFS_STATUS
            && WR_DATA[0]) begin
          n.wds = dtio_pkg::WD_RUN;
          n.wd_cnt = 15'h0000;
          n.coast = 1'b0;
        end
      end
      default: begin
        n.wds = dtio_pkg::WD_RUN;
      end
    endcase
    n.decel = n.wds == dtio_pkg::WD_DECEL;
    n.trip = n.wds == dtio_pkg::WD_TRIP;
    // ==========================================================
    // Analog inputs
    n.mon[0] = AIN1_CODE;
    n.mon[1] = AIN2_CODE;
    for (int c = 0; c < 2; c++) begin
      if (tick_hit) begin
        n.y[c] = ai_filt(s.y[c], s.mon[c], s.ai[c].ftime,
            dtio_pkg::FTIME_MAX[c]);
      end
      n.freq[c] = ai_scale(s.y[c][19:8], s.ai[c],
          s.sec[c] ? s.mainf : s.maxf);
    end
    // ==========================================================
    // Analog output and simulation
    f = int'(RUN_FREQ);
    lo = int'(s.ao_lo);
    hi = int'(s.ao_hi);
    mn = (s.ao_range == dtio_pkg::AO_4_20)
        ? int'(dtio_pkg::CODE_4MA) : 0;
    if (f <= lo) begin
      l = 0;
    end else if (f >= hi) begin
      l = int'(dtio_pkg::CODE_FULL) - mn;
    end else begin
      l = (f - lo) * (int'(dtio_pkg::CODE_FULL) - mn) / (hi - lo);
    end
    cde = (mn + l) * int'(s.comp) / dtio_pkg::PCT_ONE;
    if (cde > int'(dtio_pkg::CODE_FULL)) begin
      cde = int'(dtio_pkg::CODE_FULL);
    end
    if (ao_sim) begin
      if (key_up && s.sim_code != dtio_pkg::CODE_FULL) begin
        n.sim_code = s.sim_code + 12'h001;
      end else if (key_dn && s.sim_code != 12'h000) begin
        n.sim_code = s.sim_code - 12'h001;
      end
      n.ao_code = n.sim_code;
    end else begin
      n.ao_code = 12'(cde);
    end
    for (int j = 0; j < 3; j++) begin
      if (!STOPPED || s.sim != dtio_pkg::SIM_RELAY + 3'(j)) begin
        n.force_on[j] = 1'b0;
      end else if (key_up) begin
        n.force_on[j] = 1'b1;
      end
    end
    n.relay = n.force_on[0] | RELAY_REQ;
    n.do1 = n.force_on[1] | DO1_REQ;
    n.do2 = n.force_on[2] | DO2_REQ;
    // ==========================================================
    // Register writes
    if (WR_STROBE) begin
      case (ADDR)
        dtio_pkg::OFS_CFG: begin
          n.free_pol = WR_DATA[dtio_pkg::P_FREE];
          n.estop_pol = WR_DATA[dtio_pkg::P_ESTOP];
          n.wd_mode = WR_DATA[dtio_pkg::P_WDMODE];
          n.keypad = WR_DATA[dtio_pkg::P_KEYPAD +: 2];
          n.ao_range = WR_DATA[dtio_pkg::P_AORANGE +: 2];
          n.sec = WR_DATA[dtio_pkg::P_SEC +: 2];
        end
        dtio_pkg::OFS_TERM: begin
          n.t_free = WR_DATA[2:0];
          n.t_estop = WR_DATA[dtio_pkg::P_TESTOP +: 3];
          n.t_wd = WR_DATA[dtio_pkg::P_TWD +: 3];
          n.inv_mask = WR_DATA[dtio_pkg::P_INV +: 8];
        end
        dtio_pkg::OFS_FILT: n.filt = WR_DATA[6:0];
        dtio_pkg::OFS_WDT: n.wdt = WR_DATA[14:0];
        dtio_pkg::OFS_MAXF: n.maxf = WR_DATA[15:0];
        dtio_pkg::OFS_MAINF: n.mainf = WR_DATA[15:0];
        dtio_pkg::OFS_AOF: begin
          n.ao_lo = WR_DATA[15:0];
          n.ao_hi = WR_DATA[dtio_pkg::P_HIGH +: 16];
        end
        dtio_pkg::OFS_COMP: n.comp = WR_DATA[6:0];
        dtio_pkg::OFS_SIM: n.sim = WR_DATA[2:0];
        default: begin
        end
      endcase
      for (int c = 0; c < 2; c++) begin
        if (ADDR == dtio_pkg::OFS_LIM[c]) begin
          n.ai[c].low_lim = WR_DATA[11:0];
          n.ai[c].high_lim = WR_DATA[dtio_pkg::P_HIGH +: 12];
        end
        if (ADDR == dtio_pkg::OFS_SET[c]) begin
          n.ai[c].low_set = WR_DATA[7:0];
          n.ai[c].high_set = WR_DATA[dtio_pkg::P_HIGH +: 8];
        end
        if (ADDR == dtio_pkg::OFS_MISC[c]) begin
          n.ai[c].gain = WR_DATA[6:0];
          n.ai[c].dead = WR_DATA[dtio_pkg::P_DEAD +: 8];
          n.ai[c].ftime = WR_DATA[dtio_pkg::P_FTIME +: 9];
        end
      end
    end
    // ==========================================================
    // Register reads
    if (RD_STROBE) begin
      case (ADDR)
        dtio_pkg::OFS_CFG: n.rdata = {23'h0, s.sec, s.ao_range,
            s.keypad, s.wd_mode, s.estop_pol, s.free_pol};
        dtio_pkg::OFS_TERM: n.rdata = {8'h0, s.inv_mask, 5'h0,
            s.t_wd, 1'b0, s.t_estop, 1'b0, s.t_free};
        dtio_pkg::OFS_FILT: n.rdata = {25'h0, s.filt};
        dtio_pkg::OFS_WDT: n.rdata = {17'h0, s.wdt};
        dtio_pkg::OFS_STATUS: n.rdata = {16'h0, s.di_state, 5'h0,
            s.wds == dtio_pkg::WD_DECEL, s.coast,
            s.wds == dtio_pkg::WD_TRIP};
        dtio_pkg::OFS_MAXF: n.rdata = {16'h0, s.maxf};
        dtio_pkg::OFS_MAINF: n.rdata = {16'h0, s.mainf};
        dtio_pkg::OFS_AOF: n.rdata = {s.ao_hi, s.ao_lo};
        dtio_pkg::OFS_COMP: n.rdata = {25'h0, s.comp};
        dtio_pkg::OFS_SIM: n.rdata = {29'h0, s.sim};
        dtio_pkg::OFS_AOCODE: n.rdata = {20'h0, s.ao_code};
        default: begin
        end
      endcase
      for (int c = 0; c < 2; c++) begin
        if (ADDR == dtio_pkg::OFS_MON[c]) begin
          n.rdata = {20'h0, s.mon[c]};
        end
        if (ADDR == dtio_pkg::OFS_FREQ[c]) begin
          n.rdata = {{14{s.freq[c][17]}}, s.freq[c]};
        end
        if (ADDR == dtio_pkg::OFS_LIM[c]) begin
          n.rdata = {4'h0, s.ai[c].high_lim, 4'h0, s.ai[c].low_lim};
        end
        if (ADDR == dtio_pkg::OFS_SET[c]) begin
          n.rdata = {8'h0, s.ai[c].high_set, 8'h0, s.ai[c].low_set};
        end
        if (ADDR == dtio_pkg::OFS_MISC[c]) begin
          n.rdata = {7'h0, s.ai[c].ftime, s.ai[c].dead, 1'b0,
              s.ai[c].gain};
        end
      end
    end
    // ==========================================================
    // Synchronous reset
    if (!RESET_N) begin
      n = '0;
      n.filt = dtio_pkg::RST_FILT;
      n.wdt = dtio_pkg::RST_WDT;
      n.keypad = dtio_pkg::RST_KEYPAD;
      n.ao_range = dtio_pkg::RST_AORANGE;
      n.ao_lo = dtio_pkg::RST_AOLO;
      n.ao_hi = dtio_pkg::RST_FREQ;
      n.maxf = dtio_pkg::RST_FREQ;
      n.mainf = dtio_pkg::RST_FREQ;
      n.comp = dtio_pkg::RST_COMP;
      n.t_estop = dtio_pkg::RST_TESTOP;
      n.t_wd = dtio_pkg::RST_TWD;
      n.wds = dtio_pkg::WD_RUN;
      n.lkp = 1'b0;
      n.rkp = 1'b1;
      for (int c = 0; c < 2; c++) begin
        n.ai[c].low_lim = dtio_pkg::RST_LOLIM[c];
        n.ai[c].high_lim = dtio_pkg::RST_HILIM;
        n.ai[c].low_set = dtio_pkg::RST_LSET;
        n.ai[c].high_set = dtio_pkg::RST_HSET;
        n.ai[c].gain = dtio_pkg::RST_GAIN;
        n.ai[c].ftime = dtio_pkg::RST_FTIME;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    s <= n;
  end

  // ==========================================================
  // Outputs
  assign RD_DATA = s.rdata;
  assign FREE_STOP = s.free_stop;
  assign EMERG_STOP = s.estop;
  assign COAST_REQ = s.coast;
  assign DECEL_REQ = s.decel;
  assign WD_TRIP = s.trip;
  assign DI_STATE = s.di_state;
  assign DIAG_SEG = s.diag;
  assign RELAY_OUT = s.relay;
  assign DO1_OUT = s.do1;
  assign DO2_OUT = s.do2;
  assign LOCAL_KEYPAD_EN = s.lkp;
  assign REMOTE_KEYPAD_EN = s.rkp;
  assign AI1_FREQ = s.freq[0];
  assign AI2_FREQ = s.freq[1];
  assign AO1_CODE = s.ao_code;
  assign AO1_RANGE = s.ao_range;

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence due_coast;
    wd_due && !s.wd_mode;
  endsequence
  sequence due_decel;
    wd_due && s.wd_mode;
  endsequence

  free_pol_a: assert property (
    $past(RESET_N) |-> (FREE_STOP == (s.free_pol ? s.di_acc[s.t_free]
      : !s.di_acc[s.t_free]) || $changed(s.free_pol)
      || $changed(s.t_free) || $changed(s.di_acc)))
    else $error("free stop level does not follow polarity");
  wd_off_a: assert property (
    (s.wdt == 15'h0000 && !WD_TRIP && !DECEL_REQ) |=> !WD_TRIP
      && !DECEL_REQ)
    else $error("disabled watchdog tripped");
  coast_trip_a: assert property (
    due_coast |=> WD_TRIP && COAST_REQ && !DECEL_REQ)
    else $error("coast timeout did not trip");
  decel_trip_a: assert property (
    due_decel ##1 (DECEL_REQ && !MOTOR_STOPPED)[*2]
      |-> !WD_TRIP && !COAST_REQ)
    else $error("decelerating watchdog tripped early");
  decel_end_a: assert property (
    (DECEL_REQ && MOTOR_STOPPED) |=> WD_TRIP && !DECEL_REQ)
    else $error("trip missing after deceleration");
  wd_restart_a: assert property (
    (wd_pulse && s.wds == dtio_pkg::WD_RUN) |=> s.wd_cnt == 15'h0000)
    else $error("watchdog count not restarted by pulse");
  diag_seg_a: assert property (
    $past(RESET_N) |-> DIAG_SEG[0] == !DI_STATE[0]
      && DIAG_SEG[1] == DI_STATE[1])
    else $error("diagnostic segments disagree with inputs");
  relay_sim_a: assert property (
    (STOPPED && s.sim == dtio_pkg::SIM_RELAY && key_up) |=> RELAY_OUT
      ##1 (RELAY_OUT || !$past(STOPPED) || $changed(s.sim)))
    else $error("relay simulation did not hold output");
  ao_sim_a: assert property (
    (ao_sim && key_up && s.sim_code != dtio_pkg::CODE_FULL)
      |=> AO1_CODE == $past(s.sim_code) + 12'h001)
    else $error("analog simulation step wrong");
  keypad_a: assert property (
    (s.keypad == dtio_pkg::KP_REMOTE) |=> $past(s.keypad) != 2'h1
      || (REMOTE_KEYPAD_EN && !LOCAL_KEYPAD_EN))
    else $error("remote keypad selection wrong");
endmodule : dtio_top
